// [inc/line_port_cfg.svh]
// constants for the line port block
`ifndef LINE_PORT_CFG_SVH
`define LINE_PORT_CFG_SVH
// ==========================================
// sizes
`define LP_NCH 4
`define LP_FIFO_DEPTH 8
`define LP_SYM_W 3
`define LP_PH_W 8
// ==========================================
// timing
`define LP_CLK_HZ 200000000
`define LP_E1_BPS 2048000
`define LP_BIT_CYC (`LP_CLK_HZ / `LP_E1_BPS)
// ==========================================
// register map and reset values
`define LP_CFG_OFS 4'h0
`define LP_STAT_OFS 8'h10
`define LP_CFG_RST 9'h000
`define LP_RC_CMI 2'h1
`endif

// [inc/line_port_pkg.sv]
// types shared by the line port block
package line_port_pkg;
    typedef enum logic [1:0] {
        MODE_ANALOG = 2'b00,
        MODE_DUAL = 2'b01,
        MODE_OPTICAL = 2'b10
    } line_mode_e;

    // bit 0 is the digital line select
    typedef struct packed {
        logic tx_cmi;
        logic tx_polarity_bit;
        logic tx_full_baud_bit;
        logic tx_tristate_bit;
        logic tx_coding_bit;
        logic rx_polarity_bit;
        logic [1:0] rx_coding_field;
        logic digital_line_select;
    } line_cfg_s;

    typedef struct packed {
        logic frame_start;
        logic pos;
        logic neg;
    } tx_sym_s;

    typedef struct packed {
        logic pos;
        logic neg;
        logic valid;
    } rx_bits_s;

    typedef struct packed {
        logic tx_analog_line_a;
        logic tx_analog_line_b;
        logic analog_oe_n;
        logic tx_positive_rail_out;
        logic tx_negative_rail_out;
        logic digital_oe_n;
        logic tx_frame_marker;
    } tx_pins_s;

    function automatic line_mode_e mode_of(input logic dls, input logic code_bit);
        if (!dls) begin
            return MODE_ANALOG;
        end
        return code_bit ? MODE_DUAL : MODE_OPTICAL;
    endfunction
endpackage

// [rtl/line_port_mode_select.sv]
// line port mode selection and coding, fifo, lanes and wishbone slave
//
// Notes on behaviour
// - dual-rail receive samples rails with a clock recovered from pulses.
// - dual-rail receive when line select is 1 and upper rx code is 1.
// - receive polarity bit sets input sense; reset value means active low.
// - optical rx code 00 latches with external receive clock.
// - cmi receive ignores external clock, recovers clock and data internally.
// - analog outputs only with line select 0, else digital pins carry data.
// - analog outputs high impedance until tx coding set, tristate cleared.
// - dual-rail tx is half-baud unless full-baud bit is set.
// - dual-rail tx data launched on rising tx line clock edges.
// - tx polarity bit sets dual-rail output sense; reset gives active low.
// - dual-rail tx when line select is 1 and tx coding bit is 1.
// - digital tx pins high impedance until line select set, tristate cleared.
// - optical tx when line select is 1 and tx coding bit is 0.
// - nrz optical bits held full bit, launched on rising tx clock edge.
// - cmi optical symbols shift on both tx clock edges.
// - optical tx active high after reset unless tx polarity inverts it.
// - optical nrz receive latches data on falling external clock edge.
// - optical tx emits frame marker with first bit of each frame.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "line_port_cfg.svh"

// ==========================================
// symbol fifo
module lp_fifo #(
    parameter int W = `LP_SYM_W,
    parameter int DEPTH = `LP_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic rdy;
    } fifo_s;
    fifo_s r_reg, r_next;
    logic push, pop;

    assign in_ready_o = r_reg.rdy;
    assign out_valid_o = (r_reg.cnt != '0);
    assign out_data_o = r_reg.mem[r_reg.rp];

    always_comb begin
        r_next = r_reg;
        push = in_valid_i & r_reg.rdy;
        pop = out_ready_i & (r_reg.cnt != '0);
        if (push) begin
            r_next.mem[r_reg.wp] = in_data_i;
            r_next.wp = (r_reg.wp == AW'(DEPTH - 1)) ? '0 : AW'(r_reg.wp + 1'b1);
        end
        if (pop) begin
            r_next.rp = (r_reg.rp == AW'(DEPTH - 1)) ? '0 : AW'(r_reg.rp + 1'b1);
        end
        r_next.cnt = (AW + 1)'(r_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop));
        r_next.rdy = (r_next.cnt != (AW + 1)'(DEPTH));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
        end else begin
            r_reg <= r_next;
        end
    end
endmodule

// ==========================================
// one channel of line logic
module lp_lane
    import line_port_pkg::*;
#(
    parameter int BIT_CYC = `LP_BIT_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // settings
    input wire line_cfg_s cfg_i,
    // transmit symbol stream
    input wire tx_sym_s tx_sym_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    // line pins
    input wire logic rx_positive_rail_in_i,
    input wire logic rx_negative_rail_in_i,
    input wire logic rx_external_clock_in_i,
    input wire logic tx_line_clock_i,
    output rx_bits_s rx_o,
    output tx_pins_s tx_o
);
    localparam logic [`LP_PH_W-1:0] PH_Q = `LP_PH_W'(BIT_CYC / 4);
    localparam logic [`LP_PH_W-1:0] PH_3Q = `LP_PH_W'((3 * BIT_CYC) / 4);
    localparam logic [`LP_PH_W-1:0] PH_END = `LP_PH_W'(BIT_CYC - 1);

    typedef struct packed {
        logic [2:0] tck;
        logic [2:0] rck;
        logic [2:0] rp;
        logic [2:0] rn;
        logic [`LP_PH_W-1:0] ph;
        logic cmi_a;
        logic cmi_lvl;
        tx_sym_s sym;
        logic pos;
        logic neg;
        logic d;
        rx_bits_s rx;
        tx_pins_s pins;
    } lane_s;
    lane_s r_reg, r_next;

    line_mode_e tx_mode, rx_mode;
    logic rise, fall, rck_fall, pop, fifo_v, rx_cmi;
    logic rp_act, rp_old, rn_act, rn_old, resync;
    tx_sym_s fifo_d, sym;

    assign rise = r_reg.tck[1] & ~r_reg.tck[2];
    assign fall = ~r_reg.tck[1] & r_reg.tck[2];
    assign rck_fall = ~r_reg.rck[1] & r_reg.rck[2];
    assign pop = rise;
    assign rx_o = r_reg.rx;
    assign tx_o = r_reg.pins;

    lp_fifo #(.W(`LP_SYM_W), .DEPTH(`LP_FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i(tx_sym_i),
        .out_valid_o(fifo_v),
        .out_ready_i(pop),
        .out_data_o(fifo_d)
    );

    always_comb begin
        r_next = r_reg;
        r_next.tck = {r_reg.tck[1:0], tx_line_clock_i};
        r_next.rck = {r_reg.rck[1:0], rx_external_clock_in_i};
        r_next.rp = {r_reg.rp[1:0], rx_positive_rail_in_i};
        r_next.rn = {r_reg.rn[1:0], rx_negative_rail_in_i};
        rx_mode = mode_of(cfg_i.digital_line_select, cfg_i.rx_coding_field[1]);
        tx_mode = mode_of(cfg_i.digital_line_select, cfg_i.tx_coding_bit);
        rx_cmi = (cfg_i.rx_coding_field == `LP_RC_CMI);
        rp_act = r_reg.rp[1] ^ ~cfg_i.rx_polarity_bit;
        rp_old = r_reg.rp[2] ^ ~cfg_i.rx_polarity_bit;
        rn_act = r_reg.rn[1] ^ ~cfg_i.rx_polarity_bit;
        rn_old = r_reg.rn[2] ^ ~cfg_i.rx_polarity_bit;
        resync = 1'b0;
        if (rx_mode == MODE_DUAL) begin
            resync = (rp_act & ~rp_old) | (rn_act & ~rn_old);
        end else if (rx_mode == MODE_OPTICAL && rx_cmi) begin
            resync = (rp_act ^ rp_old) & ((r_reg.ph < PH_Q) | (r_reg.ph >= PH_3Q));
        end
        if (resync || r_reg.ph == PH_END) begin
            r_next.ph = '0;
        end else begin
            r_next.ph = `LP_PH_W'(r_reg.ph + 1'b1);
        end
        r_next.rx.valid = 1'b0;
        if (rx_mode == MODE_DUAL && r_reg.ph == PH_Q) begin
            r_next.rx = '{pos: rp_act, neg: rn_act, valid: 1'b1};
        end
        if (rx_mode == MODE_OPTICAL && rx_cmi) begin
            if (r_reg.ph == PH_Q) begin
                r_next.cmi_a = rp_act;
            end
            if (r_reg.ph == PH_3Q) begin
                r_next.rx = '{pos: (rp_act == r_reg.cmi_a), neg: 1'b0, valid: 1'b1};
            end
        end
        // external clock latches on falling edge
        if (rx_mode == MODE_OPTICAL && !rx_cmi && rck_fall) begin
            r_next.rx = '{pos: rp_act, neg: 1'b0, valid: 1'b1};
        end
        sym = fifo_v ? fifo_d : '0;
        if (rise) begin
            r_next.sym = sym;
            r_next.pos = sym.pos;
            r_next.neg = sym.neg;
            r_next.d = sym.pos;
            if (cfg_i.tx_cmi) begin
                r_next.d = sym.pos ? ~r_reg.cmi_lvl : 1'b0;
                r_next.cmi_lvl = sym.pos ? ~r_reg.cmi_lvl : r_reg.cmi_lvl;
            end
        end
        if (fall) begin
            if (!cfg_i.tx_full_baud_bit) begin
                r_next.pos = 1'b0;
                r_next.neg = 1'b0;
            end
            if (cfg_i.tx_cmi && !r_reg.sym.pos) begin
                r_next.d = 1'b1;
            end
        end
        r_next.pins.tx_analog_line_a = r_next.pos;
        r_next.pins.tx_analog_line_b = r_next.neg;
        if (tx_mode == MODE_DUAL) begin
            r_next.pins.tx_positive_rail_out = r_next.pos ^ ~cfg_i.tx_polarity_bit;
            r_next.pins.tx_negative_rail_out = r_next.neg ^ ~cfg_i.tx_polarity_bit;
        end else begin
            r_next.pins.tx_positive_rail_out = r_next.d ^ cfg_i.tx_polarity_bit;
            r_next.pins.tx_negative_rail_out = 1'b0;
        end
        r_next.pins.tx_frame_marker = (tx_mode == MODE_OPTICAL) & r_next.sym.frame_start;
        r_next.pins.analog_oe_n = ~(~cfg_i.digital_line_select & cfg_i.tx_coding_bit
            & ~cfg_i.tx_tristate_bit);
        r_next.pins.digital_oe_n = ~(cfg_i.digital_line_select & ~cfg_i.tx_tristate_bit);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '0;
            r_reg.pins.analog_oe_n <= 1'b1;
            r_reg.pins.digital_oe_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_dual_launch;
        rise && tx_mode == MODE_DUAL && fifo_v;
    endsequence
    sequence s_cmi_zero;
        rise && tx_mode == MODE_OPTICAL && cfg_i.tx_cmi && fifo_v && !fifo_d.pos;
    endsequence
    sequence s_cmi_mid;
        fall && tx_mode == MODE_OPTICAL && cfg_i.tx_cmi && !r_reg.sym.pos;
    endsequence

    property p_dig_oe;
        ##1 r_reg.pins.digital_oe_n == !$past(cfg_i.digital_line_select
            && !cfg_i.tx_tristate_bit);
    endproperty
    a_dig_oe: assert property (p_dig_oe)
        else $error("digital enable does not follow settings");
    property p_ana_oe;
        $past(cfg_i.digital_line_select) |-> r_reg.pins.analog_oe_n;
    endproperty
    a_ana_oe: assert property (p_ana_oe)
        else $error("analog output driven in digital mode");
    property p_one_driver;
        !(!r_reg.pins.analog_oe_n && !r_reg.pins.digital_oe_n);
    endproperty
    a_one_driver: assert property (p_one_driver)
        else $error("analog and digital outputs both driven");
    property p_launch;
        tx_sym_s s;
        (s_dual_launch, s = fifo_d) |=> r_reg.pos == s.pos && r_reg.neg == s.neg;
    endproperty
    a_launch: assert property (p_launch)
        else $error("dual rail symbol not launched");
    property p_half_baud;
        fall && !cfg_i.tx_full_baud_bit |=> !r_reg.pos && !r_reg.neg;
    endproperty
    a_half_baud: assert property (p_half_baud)
        else $error("half baud pulse not returned to zero");
    property p_dual_sense;
        $past(tx_mode == MODE_DUAL) |->
            r_reg.pins.tx_positive_rail_out == (r_reg.pos ^ !$past(cfg_i.tx_polarity_bit));
    endproperty
    a_dual_sense: assert property (p_dual_sense)
        else $error("dual rail output sense wrong");
    property p_opt_sense;
        $past(tx_mode == MODE_OPTICAL) |->
            r_reg.pins.tx_positive_rail_out == (r_reg.d ^ $past(cfg_i.tx_polarity_bit));
    endproperty
    a_opt_sense: assert property (p_opt_sense)
        else $error("optical output sense wrong");
    property p_cmi_zero;
        s_cmi_zero |=> !r_reg.d;
    endproperty
    a_cmi_zero: assert property (p_cmi_zero)
        else $error("cmi zero first half not low");
    property p_cmi_mid;
        s_cmi_mid |=> r_reg.d;
    endproperty
    a_cmi_mid: assert property (p_cmi_mid)
        else $error("cmi zero second half not high");
    property p_marker;
        r_reg.pins.tx_frame_marker |-> $past(tx_mode == MODE_OPTICAL);
    endproperty
    a_marker: assert property (p_marker)
        else $error("frame marker outside optical mode");
    property p_ext_latch;
        rx_mode == MODE_OPTICAL && !rx_cmi && rck_fall |=> r_reg.rx.valid
            && r_reg.rx.pos == $past(rp_act);
    endproperty
    a_ext_latch: assert property (p_ext_latch)
        else $error("optical data not latched on clock fall");
    property p_dual_rx;
        rx_mode == MODE_DUAL && r_reg.ph == PH_Q |=> r_reg.rx.valid
            && r_reg.rx.neg == $past(rn_act);
    endproperty
    a_dual_rx: assert property (p_dual_rx)
        else $error("dual rail receive sample missed");
endmodule

// ==========================================
// top: wishbone registers and four lanes
module line_port_mode_select
    import line_port_pkg::*;
#(
    parameter int NCH = `LP_NCH,
    parameter int BIT_CYC = `LP_BIT_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // transmit streams
    input wire tx_sym_s [NCH-1:0] tx_sym_i,
    input wire logic [NCH-1:0] tx_valid_i,
    output logic [NCH-1:0] tx_ready_o,
    // line pins
    input wire logic [NCH-1:0] rx_positive_rail_in_i,
    input wire logic [NCH-1:0] rx_negative_rail_in_i,
    input wire logic [NCH-1:0] rx_external_clock_in_i,
    input wire logic [NCH-1:0] tx_line_clock_i,
    output rx_bits_s [NCH-1:0] rx_o,
    output tx_pins_s [NCH-1:0] tx_o
);
    typedef struct packed {
        line_cfg_s [NCH-1:0] cfg;
        logic ack;
        logic [31:0] dat;
    } top_s;
    top_s r_reg, r_next;
    logic req, cfg_hit;
    logic [1:0] ch;

    assign wb_ack_o = r_reg.ack;
    assign wb_dat_o = r_reg.dat;

    always_comb begin
        r_next = r_reg;
        req = wb_cyc_i & wb_stb_i & ~r_reg.ack;
        ch = wb_adr_i[3:2];
        cfg_hit = (wb_adr_i[7:4] == `LP_CFG_OFS) && (wb_adr_i[1:0] == 2'h0)
            && (32'(ch) < NCH);
        r_next.ack = req;
        if (req) begin
            r_next.dat = '0;
            if (cfg_hit) begin
                r_next.dat = 32'(r_reg.cfg[ch]);
            end else if (wb_adr_i == `LP_STAT_OFS) begin
                for (int i = 0; i < NCH; i++) begin
                    r_next.dat[8*i +: 8] = {5'h00, tx_ready_o[i], rx_o[i].pos, rx_o[i].neg};
                end
            end
            if (wb_we_i && cfg_hit) begin
                if (wb_sel_i[0]) begin
                    r_next.cfg[ch][7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    r_next.cfg[ch][8] = wb_dat_i[8];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg <= '0;
            for (int i = 0; i < NCH; i++) begin
                r_reg.cfg[i] <= `LP_CFG_RST;
            end
        end else begin
            r_reg <= r_next;
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : g_lane
        lp_lane #(.BIT_CYC(BIT_CYC)) u_lane (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cfg_i(r_reg.cfg[g]),
            .tx_sym_i(tx_sym_i[g]),
            .tx_valid_i(tx_valid_i[g]),
            .tx_ready_o(tx_ready_o[g]),
            .rx_positive_rail_in_i(rx_positive_rail_in_i[g]),
            .rx_negative_rail_in_i(rx_negative_rail_in_i[g]),
            .rx_external_clock_in_i(rx_external_clock_in_i[g]),
            .tx_line_clock_i(tx_line_clock_i[g]),
            .rx_o(rx_o[g]),
            .tx_o(tx_o[g])
        );
    end
endmodule
`default_nettype wire

// [test/line_far_end.sv]
// far-side line transceiver model driving the line pins of every channel alike
`timescale 1ns/1ps
`default_nettype none
module line_far_end (
    // line clocks
    output logic tx_clk_o,
    output logic rx_clk_o,
    // receive rails, optical data on the positive one
    output logic rx_pos_o,
    output logic rx_neg_o
);
    // clocks stand still between frames
    initial begin
        tx_clk_o = 1'b0;
        rx_clk_o = 1'b0;
        rx_pos_o = 1'b0;
        rx_neg_o = 1'b1;
    end
    // ==========================================
    // half period of the 80 ns transmit clock, edge off the bench clock phase
    task automatic tx_half(input logic lvl);
        #1.3 tx_clk_o = lvl;
        #38.7;
    endtask
    // ==========================================
    // one received bit; data held around the falling clock edge, then inverted
    task automatic rx_bit(input logic b);
        rx_pos_o = b;
        rx_neg_o = ~b;
        #21.3 rx_clk_o = 1'b1;
        #20 rx_clk_o = 1'b0;
        #20 rx_pos_o = ~b;
        rx_neg_o = b;
        #18.7;
    endtask
    // ==========================================
    // one dual-rail bit: idle rails, half-bit pulse on chosen rails, idle again
    task automatic rx_dual(input logic p, input logic n);
        rx_pos_o = 1'b0;
        rx_neg_o = 1'b0;
        #101.3 rx_pos_o = p;
        rx_neg_o = n;
        #244 rx_pos_o = 1'b0;
        rx_neg_o = 1'b0;
        #142.7;
    endtask
endmodule
`default_nettype wire

// [test/line_port_mode_select_test.sv]
// self-checking bench for the line port block
`timescale 1ns/1ps
`default_nettype none
module line_port_mode_select_test
    import line_port_pkg::*;
();
    localparam int NCH = 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    tx_sym_s [NCH-1:0] tx_sym_i = 12'h000;
    logic [NCH-1:0] tx_valid_i = 4'h0;
    logic [NCH-1:0] tx_ready_o;
    rx_bits_s [NCH-1:0] rx_o;
    tx_pins_s [NCH-1:0] tx_o;
    logic tx_clk;
    logic rx_clk;
    logic rx_pos;
    logic rx_neg;
    logic [31:0] rd;
    logic rx_q[$];
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [8:0] cfg_tab[6] = '{9'h000, 9'h010, 9'h030, 9'h001, 9'h011, 9'h021};
    logic [1:0] oe_tab[6] = '{2'h3, 2'h1, 2'h3, 2'h2, 2'h2, 2'h3};
    logic [7:0] pat = 8'h4D;
    logic [3:0] rx_pat = 4'hD;

    always #2.5 clk_i = ~clk_i;

    line_port_mode_select #(.NCH(NCH)) line_port_mode_select_inst (
        .clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .tx_sym_i(tx_sym_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .rx_positive_rail_in_i({NCH{rx_pos}}), .rx_negative_rail_in_i({NCH{rx_neg}}),
        .rx_external_clock_in_i({NCH{rx_clk}}), .tx_line_clock_i({NCH{tx_clk}}),
        .rx_o(rx_o), .tx_o(tx_o)
    );

    line_far_end line_far_end_inst (
        .tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .rx_pos_o(rx_pos), .rx_neg_o(rx_neg)
    );

    // ==========================================
    // tasks
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           input logic [3:0] sel = 4'hF);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic set_cfg(input logic [7:0] adr, input logic [8:0] v);
        wb_xfer(1'b1, adr, {23'h000000, v});
    endtask

    task automatic push(input tx_sym_s s, input logic [NCH-1:0] m = 4'h1);
        @(posedge clk_i);
        tx_sym_i <= {NCH{s}};
        tx_valid_i <= m;
        @(posedge clk_i);
        tx_valid_i <= '0;
    endtask

    task automatic half_look(input logic lvl, input logic [1:0] exp);
        line_far_end_inst.tx_half(lvl);
        @(negedge clk_i);
        check("tx rails", {30'h0, tx_o[0].tx_positive_rail_out, tx_o[0].tx_negative_rail_out},
              {30'h0, exp});
    endtask

    // ==========================================
    // receive capture and timeout
    always @(posedge clk_i) begin
        if (rx_o[0].valid === 1'b1) begin
            rx_q.push_back(rx_o[0].pos);
        end
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check("reset oe", {30'h0, tx_o[0].analog_oe_n, tx_o[0].digital_oe_n}, 32'h3);
        check("reset ready", {28'h0, tx_ready_o}, 32'hF);
        wb_xfer(1'b1, 8'h20, 32'hFFFF_FFFF);
        wb_xfer(1'b0, 8'h20, 32'h0000_0000);
        check("unmapped read", rd, 32'h0000_0000);
        set_cfg(8'h04, 9'h011);
        wb_xfer(1'b0, 8'h04, 32'h0000_0000);
        check("cfg readback", rd, 32'h0000_0011);
        wb_xfer(1'b1, 8'h04, 32'h0000_01FF, 4'h2);
        wb_xfer(1'b0, 8'h04, 32'h0000_0000);
        check("cfg byte enable", rd, 32'h0000_0111);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            set_cfg(8'h00, cfg_tab[i]);
            repeat (3) @(negedge clk_i);
            check("oe ch0", {30'h0, tx_o[0].analog_oe_n, tx_o[0].digital_oe_n}, {30'h0, oe_tab[i]});
            check("oe ch1", {30'h0, tx_o[1].analog_oe_n, tx_o[1].digital_oe_n}, 32'h2);
        end
        $display("test output enables done");
        set_cfg(8'h00, 9'h051);
        for (int i = 0; i < 8; i++) push({1'b0, pat[i], ~pat[i]});
        @(negedge clk_i);
        check("fifo full", {31'h0, tx_ready_o[0]}, 32'h0);
        push(3'b010);
        for (int i = 0; i < 8; i++) begin
            half_look(1'b1, {~pat[i], pat[i]});
            half_look(1'b0, {~pat[i], pat[i]});
        end
        half_look(1'b1, 2'b11);
        half_look(1'b0, 2'b11);
        check("fifo drained", {31'h0, tx_ready_o[0]}, 32'h1);
        check("marker dual", {31'h0, tx_o[0].tx_frame_marker}, 32'h0);
        $display("test fifo and full baud done");
        set_cfg(8'h00, 9'h011);
        push(3'b010, 4'h3);
        half_look(1'b1, 2'b01);
        check("tx rails ch1", {30'h0, tx_o[1].tx_positive_rail_out, tx_o[1].tx_negative_rail_out},
              32'h1);
        half_look(1'b0, 2'b11);
        set_cfg(8'h00, 9'h091);
        push(3'b010);
        half_look(1'b1, 2'b10);
        half_look(1'b0, 2'b00);
        $display("test half baud done");
        set_cfg(8'h00, 9'h001);
        push(3'b110);
        line_far_end_inst.tx_half(1'b1);
        @(negedge clk_i);
        check("optical out", {31'h0, tx_o[0].tx_positive_rail_out}, 32'h1);
        check("marker", {31'h0, tx_o[0].tx_frame_marker}, 32'h1);
        line_far_end_inst.tx_half(1'b0);
        @(negedge clk_i);
        check("optical nrz", {31'h0, tx_o[0].tx_positive_rail_out}, 32'h1);
        set_cfg(8'h00, 9'h081);
        push(3'b010);
        line_far_end_inst.tx_half(1'b1);
        @(negedge clk_i);
        check("optical inv", {31'h0, tx_o[0].tx_positive_rail_out}, 32'h0);
        line_far_end_inst.tx_half(1'b0);
        set_cfg(8'h00, 9'h101);
        push(3'b000);
        line_far_end_inst.tx_half(1'b1);
        @(negedge clk_i);
        check("cmi first half", {31'h0, tx_o[0].tx_positive_rail_out}, 32'h0);
        line_far_end_inst.tx_half(1'b0);
        @(negedge clk_i);
        check("cmi second half", {31'h0, tx_o[0].tx_positive_rail_out}, 32'h1);
        $display("test optical transmit done");
        set_cfg(8'h00, 9'h009);
        rx_q.delete();
        for (int i = 0; i < 4; i++) line_far_end_inst.rx_bit(rx_pat[i]);
        repeat (10) @(negedge clk_i);
        check("rx count", rx_q.size(), 32'h4);
        for (int i = 0; i < 4; i++) check("rx bit", {31'h0, rx_q[i]}, {31'h0, rx_pat[i]});
        set_cfg(8'h00, 9'h001);
        rx_q.delete();
        for (int i = 0; i < 2; i++) line_far_end_inst.rx_bit(rx_pat[i]);
        repeat (10) @(negedge clk_i);
        check("rx inv count", rx_q.size(), 32'h2);
        for (int i = 0; i < 2; i++) check("rx inv bit", {31'h0, rx_q[i]}, {31'h0, ~rx_pat[i]});
        $display("test optical receive done");
        set_cfg(8'h00, 9'h00D);
        line_far_end_inst.rx_dual(1'b1, 1'b0);
        @(negedge clk_i);
        check("dual rx pos", {30'h0, rx_o[0].pos, rx_o[0].neg}, 32'h2);
        line_far_end_inst.rx_dual(1'b0, 1'b1);
        @(negedge clk_i);
        check("dual rx neg", {30'h0, rx_o[0].pos, rx_o[0].neg}, 32'h1);
        $display("test dual rail receive done");
        print_verdict();
    end
endmodule
`default_nettype wire
